// >>> audio_route_pkg.sv
package audio_route_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int            REG_COUNT  = 8;
  localparam logic [7:0]    BANK_BASE  = 8'h14;
  localparam logic [7:0]    SA_SCART1  = 8'h14;
  localparam logic [7:0]    SA_SCART2  = 8'h15;
  localparam logic [7:0]    SA_LINE    = 8'h16;
  localparam logic [7:0]    SA_ADC     = 8'h17;
  localparam logic [7:0]    SA_MAIN    = 8'h18;
  localparam logic [7:0]    SA_EFFECTS = 8'h19;
  localparam logic [7:0]    SA_VOL_L   = 8'h1a;
  localparam logic [7:0]    SA_VOL_R   = 8'h1b;

  localparam logic [2:0]    IX_SCART1  = 3'h0;
  localparam logic [2:0]    IX_SCART2  = 3'h1;
  localparam logic [2:0]    IX_LINE    = 3'h2;
  localparam logic [2:0]    IX_ADC     = 3'h3;
  localparam logic [2:0]    IX_MAIN    = 3'h4;
  localparam logic [2:0]    IX_EFFECTS = 3'h5;
  localparam logic [2:0]    IX_VOL_L   = 3'h6;
  localparam logic [2:0]    IX_VOL_R   = 3'h7;

  // power-up values and writable-bit masks, indexed from the bank base
  localparam logic [7:0] REG_RESET [REG_COUNT] =
    '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hac, 8'hac};
  localparam logic [7:0] REG_MASK [REG_COUNT] =
    '{8'h77, 8'h77, 8'h71, 8'hff, 8'h77, 8'h3f, 8'hff, 8'hff};

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int OUT_SRC_LSB    = 0;
  localparam int OUT_MODE_LSB   = 4;
  localparam int OUT_BOOST_BIT  = 6;
  localparam int LINE_ANALOG_BIT = 0;
  localparam int ADC_LEVEL_LSB  = 0;
  localparam int ADC_SRC_LSB    = 5;
  localparam int MAIN_SRC_LSB   = 0;
  localparam int MAIN_MTX_LSB   = 4;
  localparam int AUTO_LEVEL_LSB = 0;
  localparam int MONO_LSB       = 2;
  localparam int STEREO_LSB     = 4;

  // ----------------------------------------------------------------------
  // codes and levels
  // ----------------------------------------------------------------------
  localparam logic [2:0] OUT_SRC_MAX   = 3'h4;
  localparam logic [2:0] ADC_SRC_MAX   = 3'h3;
  localparam logic [2:0] MAIN_SRC_ADC  = 3'h4;
  localparam logic [2:0] MAIN_MTX_MAX  = 3'h4;
  localparam logic [1:0] AUTO_LEVEL_OFF = 2'h0;
  localparam logic [4:0] ADC_MUTE_CODE = 5'h10;
  localparam logic signed [5:0] ADC_XBAR_OFFSET_DB = -6'sd6;
  localparam logic [7:0] VOL_MUTE_CODE = 8'hac;
  localparam logic signed [7:0] VOL_MAX_DB = 8'sd24;
  localparam logic signed [7:0] VOL_MIN_DB = -8'sd83;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] chan_mode;
    logic       boost;
  } euro_out_t;

  typedef struct packed {
    logic [1:0] chan_mode;
    logic       boost;
    logic       src_is_analog;
    logic [2:0] prog_src;
  } line_out_t;

  typedef struct packed {
    logic [2:0]        src;
    logic              mute;
    logic signed [5:0] trim_db;
    logic signed [5:0] xbar_db;
  } adc_cfg_t;

  typedef struct packed {
    logic              mute;
    logic signed [7:0] gain_db;
  } volume_t;

endpackage

// >>> audio_route_volume_regs.sv
// Notes on behaviour
// - scart 2 output source from bits 2..0; scart 1 uses same coding.
// - bits 5..4 set channel mode: pass, left both, right both, swap.
// - scart 1 bit 6 adds 3 dB boost; register resets to 0x01.
// - scart 2 bit 6 adds 3 dB boost; register resets to zero.
// - line bit 0 high means analog main source via adc, else digital.
// - line bit 6 enables 3 dB boost at the line output buffers.
// - line output carries the main programme before main processing.
// - adc source from bits 7..5; no channel matrix on this selector.
// - adc level bits 4..0 signed dB, +15 to -15; 10000 mutes.
// - at 0 dB trim, full-scale adc input sits 6 dB below full scale.
// - main source from bits 2..0: fm, nicam, serial 1, serial 2, adc.
// - main matrix bits 6..4: pass, left, right, swap, average.
// - effects bits 1..0 set auto level mode: off, short, medium, long.
// - selecting auto level off returns its hardware to initial state.
// - effects bits 3..2 set mono widening: off, 300, 200, 150 Hz.
// - effects bits 5..4 set stereo widening: off, 30, 40, 52 percent.
// - main volume left at 26, right at 27; balance by differing values.
// - main volume signed dB +24 to -83; 0xac mutes and is power-up.
module audio_route_volume_regs
  import audio_route_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_subaddr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_subaddr,
  output      logic [7:0] rd_data,
  output      logic       rd_hit,
  output      euro_out_t  scart1_out,
  output      euro_out_t  scart2_out,
  output      line_out_t  line_out,
  output      adc_cfg_t   adc_cfg,
  output      logic [2:0] main_src,
  output      logic [2:0] main_matrix,
  output      logic [1:0] auto_level_control,
  output      logic       auto_level_clear,
  output      logic       auto_level_stale,
  output      logic [1:0] mono_widen_mode,
  output      logic [1:0] stereo_widen_mode,
  output      volume_t    volume_left,
  output      volume_t    volume_right,
  output      logic       code_error
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [7:0] wr_offset;
  logic [7:0] rd_offset;
  logic       wr_in_bank;
  logic       rd_in_bank;
  logic [7:0] bank_q [REG_COUNT];
  logic [REG_COUNT-1:0] wr_sel;

  assign wr_offset  = wr_subaddr - BANK_BASE;
  assign rd_offset  = rd_subaddr - BANK_BASE;
  assign wr_in_bank = (wr_subaddr >= BANK_BASE) &&
                      (wr_offset < 8'(REG_COUNT));
  assign rd_in_bank = (rd_subaddr >= BANK_BASE) &&
                      (rd_offset < 8'(REG_COUNT));

  // ----------------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_bank
      assign wr_sel[gi] = wr_en && wr_in_bank &&
                          (wr_offset[2:0] == 3'(gi));
      cfg_reg #(
        .RESET_VAL (REG_RESET[gi]),
        .WR_MASK   (REG_MASK[gi])
      ) u_reg (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .we    (wr_sel[gi]),
        .din   (wr_data),
        .q     (bank_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------------
  logic [7:0] scart1_q;
  logic [7:0] scart2_q;
  logic [7:0] line_q;
  logic [7:0] adc_q;
  logic [7:0] main_q;
  logic [7:0] effects_q;
  logic [7:0] vol_l_q;
  logic [7:0] vol_r_q;

  assign scart1_q  = bank_q[IX_SCART1];
  assign scart2_q  = bank_q[IX_SCART2];
  assign line_q    = bank_q[IX_LINE];
  assign adc_q     = bank_q[IX_ADC];
  assign main_q    = bank_q[IX_MAIN];
  assign effects_q = bank_q[IX_EFFECTS];
  assign vol_l_q   = bank_q[IX_VOL_L];
  assign vol_r_q   = bank_q[IX_VOL_R];

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic euro_out_t euro_decode(input logic [7:0] r);
    euro_out_t e;
    e.src       = r[OUT_SRC_LSB +: 3];
    e.chan_mode = r[OUT_MODE_LSB +: 2];
    e.boost     = r[OUT_BOOST_BIT];
    return e;
  endfunction

  // out-of-range codes are treated as mute: safest for the speakers
  function automatic volume_t vol_decode(input logic [7:0] r);
    volume_t           v;
    logic signed [7:0] s;
    s = signed'(r);
    v.gain_db = s;
    v.mute    = (r == VOL_MUTE_CODE) || (s > VOL_MAX_DB) ||
                (s < VOL_MIN_DB);
    return v;
  endfunction

  function automatic logic vol_bad(input logic [7:0] r);
    logic signed [7:0] s;
    s = signed'(r);
    return (r != VOL_MUTE_CODE) && ((s > VOL_MAX_DB) || (s < VOL_MIN_DB));
  endfunction

  // ----------------------------------------------------------------------
  // analog output routing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scart1_out <= euro_decode(REG_RESET[IX_SCART1]);
      scart2_out <= euro_decode(REG_RESET[IX_SCART2]);
    end else if (ce) begin
      scart1_out <= euro_decode(scart1_q);
      scart2_out <= euro_decode(scart2_q);
    end
  end

  // ----------------------------------------------------------------------
  // line output
  // ----------------------------------------------------------------------
  // programme tapped at the main selector, ahead of effects and volume
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_out <= '0;
    end else if (ce) begin
      line_out.chan_mode     <= line_q[OUT_MODE_LSB +: 2];
      line_out.boost         <= line_q[OUT_BOOST_BIT];
      line_out.src_is_analog <= line_q[LINE_ANALOG_BIT];
      line_out.prog_src      <= main_q[MAIN_SRC_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------------
  // adc selector and level trim
  // ----------------------------------------------------------------------
  logic [4:0]        adc_level;
  logic signed [5:0] adc_trim;

  assign adc_level = adc_q[ADC_LEVEL_LSB +: 5];
  assign adc_trim  = 6'(signed'(adc_level));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      adc_cfg <= '0;
      adc_cfg.xbar_db <= ADC_XBAR_OFFSET_DB;
    end else if (ce) begin
      adc_cfg.src     <= adc_q[ADC_SRC_LSB +: 3];
      adc_cfg.mute    <= (adc_level == ADC_MUTE_CODE);
      adc_cfg.trim_db <= adc_trim;
      // at 0 dB trim, full-scale analog input lands 6 dB under full scale
      adc_cfg.xbar_db <= 6'(adc_trim + ADC_XBAR_OFFSET_DB);
    end
  end

  // ----------------------------------------------------------------------
  // main channel selector
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      main_src    <= '0;
      main_matrix <= '0;
    end else if (ce) begin
      main_src    <= main_q[MAIN_SRC_LSB +: 3];
      main_matrix <= main_q[MAIN_MTX_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------------
  // effects
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_level_control <= AUTO_LEVEL_OFF;
      mono_widen_mode    <= '0;
      stereo_widen_mode  <= '0;
    end else if (ce) begin
      auto_level_control <= effects_q[AUTO_LEVEL_LSB +: 2];
      mono_widen_mode    <= effects_q[MONO_LSB +: 2];
      stereo_widen_mode  <= effects_q[STEREO_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // auto level restart
  // ----------------------------------------------------------------------
  logic level_off_write;
  logic src_change_write;

  assign level_off_write = wr_sel[IX_EFFECTS] &&
                         (wr_data[AUTO_LEVEL_LSB +: 2] == AUTO_LEVEL_OFF);
  assign src_change_write = wr_sel[IX_MAIN] &&
                            (wr_data[MAIN_SRC_LSB +: 3] !=
                             main_q[MAIN_SRC_LSB +: 3]);

  // one-cycle clear on every write of the off setting, even if already off
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_level_clear <= 1'b1;
    end else if (ce) begin
      auto_level_clear <= level_off_write;
    end
  end

  // warns that the controller still owes the off/on cycle after a switch;
  // the level tracker would otherwise settle slowly on the new source
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_level_stale <= 1'b0;
    end else if (ce) begin
      if (src_change_write &&
          (effects_q[AUTO_LEVEL_LSB +: 2] != AUTO_LEVEL_OFF)) begin
        auto_level_stale <= 1'b1;
      end else if (level_off_write) begin
        auto_level_stale <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // main volume
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      volume_left  <= vol_decode(REG_RESET[IX_VOL_L]);
      volume_right <= vol_decode(REG_RESET[IX_VOL_R]);
    end else if (ce) begin
      volume_left  <= vol_decode(vol_l_q);
      volume_right <= vol_decode(vol_r_q);
    end
  end

  // ----------------------------------------------------------------------
  // unlisted codes
  // ----------------------------------------------------------------------
  // flags codes with no defined meaning; hardware still acts on them
  logic any_bad;

  assign any_bad = (scart1_q[OUT_SRC_LSB +: 3] > OUT_SRC_MAX) ||
                   (scart2_q[OUT_SRC_LSB +: 3] > OUT_SRC_MAX) ||
                   (adc_q[ADC_SRC_LSB +: 3] > ADC_SRC_MAX) ||
                   (main_q[MAIN_SRC_LSB +: 3] > MAIN_SRC_ADC) ||
                   (main_q[MAIN_MTX_LSB +: 3] > MAIN_MTX_MAX) ||
                   vol_bad(vol_l_q) || vol_bad(vol_r_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_error <= 1'b0;
    end else if (ce) begin
      code_error <= any_bad;
    end
  end

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  // outside the bank reads return zero with rd_hit low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= '0;
      rd_hit  <= 1'b0;
    end else if (ce) begin
      rd_hit  <= rd_in_bank;
      rd_data <= rd_in_bank ? bank_q[rd_offset[2:0]] : 8'h00;
    end
  end

endmodule // audio_route_volume_regs

// >>> audio_route_volume_regs_monitor.sv
module audio_route_volume_regs_monitor
  import audio_route_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       wr_en,
  input wire logic [7:0] wr_subaddr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_subaddr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_hit,
  input wire euro_out_t  scart1_out,
  input wire euro_out_t  scart2_out,
  input wire line_out_t  line_out,
  input wire adc_cfg_t   adc_cfg,
  input wire logic [2:0] main_src,
  input wire logic [2:0] main_matrix,
  input wire logic [1:0] auto_level_control,
  input wire logic       auto_level_clear,
  input wire logic [1:0] mono_widen_mode,
  input wire logic [1:0] stereo_widen_mode,
  input wire volume_t    volume_left,
  input wire volume_t    volume_right
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // decoded outputs land two edges after the write, so keep its data
  logic       wr_go;
  logic [7:0] wd_q1;
  logic [7:0] wd_q2;
  assign wr_go = rst_b && ce && wr_en;
  always_ff @(posedge clk) begin
    wd_q1 <= wr_data;
    wd_q2 <= wd_q1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RST_DEFAULTS: assert property (disable iff (1'b0)
    !rst_b && ce |=> scart1_out == 6'h08 && volume_left.mute
      && volume_right.mute && adc_cfg.xbar_db == ADC_XBAR_OFFSET_DB)
    else $error("defaults not loaded by reset");
  AST_SCART2_DECODE: assert property (
    wr_go && wr_subaddr == SA_SCART2 ##1 ce |=>
      scart2_out == {wd_q2[2:0], wd_q2[5:4], wd_q2[6]})
    else $error("scart 2 decode wrong");
  AST_SCART1_DECODE: assert property (
    wr_go && wr_subaddr == SA_SCART1 ##1 ce |=>
      scart1_out.boost == wd_q2[6] && scart1_out.src == wd_q2[2:0])
    else $error("scart 1 decode wrong");
  AST_LINE_PROG: assert property (
    line_out.prog_src == main_src)
    else $error("line programme differs from main source");
  AST_LINE_FLAGS: assert property (
    wr_go && wr_subaddr == SA_LINE ##1 ce |=>
      line_out.src_is_analog == wd_q2[0] && line_out.boost == wd_q2[6])
    else $error("line flags wrong");
  AST_ADC_XBAR: assert property (
    !adc_cfg.mute |-> adc_cfg.xbar_db == adc_cfg.trim_db - 6'sd6)
    else $error("adc crossbar level not trim minus 6");
  AST_ADC_MUTE: assert property (
    wr_go && wr_subaddr == SA_ADC && wr_data[4:0] == ADC_MUTE_CODE
      ##1 ce |=> adc_cfg.mute && adc_cfg.src == wd_q2[7:5])
    else $error("adc mute code not honoured");
  AST_MAIN_SEL: assert property (
    wr_go && wr_subaddr == SA_MAIN ##1 ce |=>
      main_src == wd_q2[2:0] && main_matrix == wd_q2[6:4])
    else $error("main select decode wrong");
  AST_EFFECTS: assert property (
    wr_go && wr_subaddr == SA_EFFECTS ##1 ce |=> {stereo_widen_mode,
      mono_widen_mode, auto_level_control} == wd_q2[5:0])
    else $error("effects decode wrong");
  AST_AVL_CLEAR: assert property (
    wr_go && wr_subaddr == SA_EFFECTS && wr_data[1:0] == AUTO_LEVEL_OFF
      |-> ##[1:2] auto_level_clear)
    else $error("level control not cleared on off");
  AST_VOL_MUTE: assert property (
    wr_go && wr_subaddr == SA_VOL_L && wr_data == VOL_MUTE_CODE
      ##1 ce |=> volume_left.mute)
    else $error("left volume mute code not muting");
  AST_VOL_GAIN: assert property (
    wr_go && wr_subaddr == SA_VOL_R && $signed(wr_data) <= 24
      && $signed(wr_data) >= -83 ##1 ce |=>
      !volume_right.mute && volume_right.gain_db == wd_q2)
    else $error("right volume gain wrong");
  AST_RD_MISS: assert property (
    ce && !(rd_subaddr inside {[8'h14:8'h1b]}) |=> !rd_hit && rd_data == 0)
    else $error("read outside bank returned data");
  cover property (wr_go && wr_subaddr == SA_VOL_L);
  cover property (auto_level_clear && rst_b);
  cover property (adc_cfg.mute && rst_b);
endmodule // audio_route_volume_regs_monitor

bind audio_route_volume_regs audio_route_volume_regs_monitor u_mon (
  .clk(clk), .rst_b(rst_b), .ce(ce), .wr_en(wr_en),
  .wr_subaddr(wr_subaddr), .wr_data(wr_data), .rd_subaddr(rd_subaddr),
  .rd_data(rd_data), .rd_hit(rd_hit), .scart1_out(scart1_out),
  .scart2_out(scart2_out), .line_out(line_out), .adc_cfg(adc_cfg),
  .main_src(main_src), .main_matrix(main_matrix),
  .auto_level_control(auto_level_control),
  .auto_level_clear(auto_level_clear), .mono_widen_mode(mono_widen_mode),
  .stereo_widen_mode(stereo_widen_mode), .volume_left(volume_left),
  .volume_right(volume_right));

// >>> audio_route_volume_regs_tb_top.sv
module audio_route_volume_regs_tb_top
  import audio_route_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, ce, wr_en, rd_hit, clr_seen;
  logic        auto_level_clear, auto_level_stale, code_error;
  logic [7:0]  wr_subaddr, wr_data, rd_subaddr, rd_data;
  logic [2:0]  main_src, main_matrix;
  logic [1:0]  auto_level_control, mono_widen_mode, stereo_widen_mode;
  logic signed [5:0] t;
  euro_out_t   scart1_out, scart2_out;
  line_out_t   line_out;
  adc_cfg_t    adc_cfg;
  volume_t     volume_left, volume_right;
  int          err_total, checked;
  logic [4:0]  lv [4] = '{5'h0f, 5'h11, 5'h00, 5'h1f};

  audio_route_volume_regs DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
    .wr_en(wr_en), .wr_subaddr(wr_subaddr), .wr_data(wr_data),
    .rd_subaddr(rd_subaddr), .rd_data(rd_data), .rd_hit(rd_hit),
    .scart1_out(scart1_out), .scart2_out(scart2_out),
    .line_out(line_out), .adc_cfg(adc_cfg), .main_src(main_src),
    .main_matrix(main_matrix), .auto_level_control(auto_level_control),
    .auto_level_clear(auto_level_clear),
    .auto_level_stale(auto_level_stale),
    .mono_widen_mode(mono_widen_mode),
    .stereo_widen_mode(stereo_widen_mode), .volume_left(volume_left),
    .volume_right(volume_right), .code_error(code_error));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = w;
    wr_subaddr = a;
    wr_data = d;
    rd_subaddr = a;
  endtask
  // write, then let register and decode both land; reads back too
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, a, d);
    cyc(1'b0, a, d);
    clr_seen = auto_level_clear;
    cyc(1'b0, a, d);
    clr_seen = clr_seen | auto_level_clear;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rst_b, wr_en, wr_subaddr, wr_data, rd_subaddr} = '0;
    ce = 1'b1;
    err_total = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    chk(scart1_out, 16'h0008);
    chk({volume_left.mute, volume_right.mute}, 16'h3);
    for (int a = 8'h13; a <= 8'h1c; a++) begin
      cyc(1'b0, 8'(a), 8'h00);
      cyc(1'b0, 8'(a), 8'h00);
      chk(rd_hit, 16'(a >= 8'h14 && a <= 8'h1b));
      chk(rd_data, (a >= 8'h14 && a <= 8'h1b) ?
          REG_RESET[a - 8'h14] : 8'h00);
    end
    for (int i = 0; i < REG_COUNT; i++) begin
      put(8'(BANK_BASE + i), 8'hff);
      chk(rd_data, REG_MASK[i]);
    end
    chk(code_error, 16'h1);
    // level control off before the source sweep below
    put(SA_EFFECTS, 8'h00);
    for (int i = 0; i < 5; i++) begin
      put(SA_SCART1, {1'b0, i[0], i[1:0], 1'b0, i[2:0]});
      chk(scart1_out, {i[2:0], i[1:0], i[0]});
      put(SA_SCART2, {1'b0, ~i[0], i[1:0], 1'b0, i[2:0]});
      chk(scart2_out, {i[2:0], i[1:0], ~i[0]});
      put(SA_MAIN, {1'b0, i[2:0], 1'b0, i[2:0]});
      chk({main_src, main_matrix}, {i[2:0], i[2:0]});
      chk(line_out.prog_src, i[2:0]);
    end
    chk(auto_level_stale, 16'h0);
    put(SA_LINE, 8'h61);
    chk(line_out, {2'h2, 1'b1, 1'b1, 3'h4});
    put(SA_LINE, 8'h30);
    chk(line_out, {2'h3, 1'b0, 1'b0, 3'h4});
    for (int i = 0; i < 4; i++) begin
      put(SA_ADC, {1'b0, i[1:0], lv[i]});
      t = {lv[i][4], lv[i]};
      chk(adc_cfg, {1'b0, i[1:0], 1'b0, t, t - 6'sd6});
    end
    put(SA_ADC, 8'h70);
    chk({adc_cfg.src, adc_cfg.mute}, 16'h7);
    chk(code_error, 16'h0);
    // only one widening effect at a time, as one sound mode would ask
    for (int k = 0; k < 4; k++) begin
      put(SA_EFFECTS, {2'b00, k[1:0], 2'b00, k[1:0]});
      chk({stereo_widen_mode, mono_widen_mode, auto_level_control},
          {k[1:0], 2'b00, k[1:0]});
      put(SA_EFFECTS, {4'h0, k[1:0], k[1:0]});
      chk({stereo_widen_mode, mono_widen_mode, auto_level_control},
          {2'b00, k[1:0], k[1:0]});
    end
    put(SA_EFFECTS, 8'h0c);
    chk(clr_seen, 16'h1);
    put(SA_EFFECTS, 8'h01);
    chk(clr_seen, 16'h0);
    // source switch with level control on, then the owed off/on cycle
    put(SA_MAIN, 8'h41);
    chk(auto_level_stale, 16'h1);
    put(SA_EFFECTS, 8'h00);
    chk(auto_level_stale, 16'h0);
    put(SA_EFFECTS, 8'h01);
    put(SA_VOL_L, 8'h18);
    put(SA_VOL_R, 8'had);
    chk(volume_left, {1'b0, 8'h18});
    chk(volume_right, {1'b0, 8'had});
    put(SA_VOL_L, 8'hac);
    chk(volume_left.mute, 16'h1);
    put(SA_VOL_R, 8'h00);
    chk(volume_right, 16'h0);
    // an out-of-bank write at 0x1c, whose low bits match scart 1, must leave the main selector unchanged
    put(8'h1c, 8'h00);
    chk({main_src, main_matrix}, 16'h0c);
    @(negedge clk) ce = 1'b0;
    put(SA_VOL_R, 8'h05);
    chk(volume_right, 16'h0);
    @(negedge clk) ce = 1'b1;
    @(negedge clk) rst_b = 1'b0;
    @(negedge clk) rst_b = 1'b1;
    chk(scart1_out, 16'h0008);
    chk({volume_left.mute, volume_right.mute}, 16'h3);
    wrap_up();
  end
endmodule // audio_route_volume_regs_tb_top

// >>> cfg_reg.sv
module cfg_reg
  import audio_route_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       we,
  input  wire logic [7:0] din,
  output      logic [7:0] q
);

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  // fixed-zero bits are never stored, so they always read back as zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= RESET_VAL;
    end else if (ce && we) begin
      q <= din & WR_MASK;
    end
  end

endmodule // cfg_reg
